// File: design/nested_priority_interrupt_ctrl.sv
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "nic_cfg.svh"
module nested_priority_interrupt_ctrl
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // Register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  // Core side
  input  wire nic_pkg::core_evt_t core_evt_i,
  output nic_pkg::svc_cmd_t      svc_cmd_o,
  output logic      [1:0]        cc_level_o,
  output logic                   halted_o,
  output logic                   waiting_o,
  // Peripheral sources, slots 1 to 13
  input  wire logic [13:1]       periph_flag_i,
  input  wire logic [13:1]       periph_en_i,
  input  wire logic [13:1]       periph_clr_i,
  // Pins
  input  wire logic              tli_pin_i,
  input  wire logic [5:0]        ext_pin_i
);

  // Two-bit level encoding to a rank, 0 lowest
  function automatic logic [1:0] lvl_rank(input logic [1:0] enc);
    logic [1:0] r;
    r = 2'h0;
    case (enc)
      2'b10:   r = 2'h0;
      2'b01:   r = 2'h1;
      2'b00:   r = 2'h2;
      default: r = 2'h3;
    endcase
    return r;
  endfunction

  nic_pkg::ctl_state_t state_reg;
  nic_pkg::ctl_state_t state_next;
  logic [1:0]          prio_reg [0:13];
  logic [7:0]          misc1_reg;
  logic [7:0]          misc3_reg;
  logic [1:0]          level_reg;
  logic [1:0]          level_next;
  logic                halted_reg;
  logic                waiting_reg;
  logic                trap_pend_reg;
  logic                tli_pend_reg;
  logic [13:1]         lat_reg;
  logic [13:1]         lat_next;
  logic [13:1]         pend;
  logic [6:0]          pin_meta_reg;
  logic [6:0]          pin_sync_reg;
  logic                tli_prev_reg;
  logic [2:0]          ext_prev_reg;
  logic [2:0]          ext_level;
  logic [2:0]          ext_evt;
  logic [2:0]          ext_is_level;
  logic [15:0]         sel_vec_reg;
  logic [1:0]          sel_lvl_reg;
  logic                sel_stack_reg;
  logic [3:0]          sel_idx_reg;
  logic                sel_mask_reg;
  logic                best_valid;
  logic [3:0]          best_idx;
  logic [1:0]          best_rank;
  logic                win_valid;
  logic [15:0]         win_vec;
  logic [1:0]          win_lvl;
  logic                take;
  logic                sleeping;
  logic                tli_edge;
  logic [13:0]         halt_cap;
  logic [7:0]          rd_mux;
  logic [13:0]         pend_all;

  assign halt_cap = `NIC_HALT_CAP;
  assign sleeping = halted_reg | waiting_reg;

  // Pins are asynchronous to the core clock, two flops before any use
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      pin_meta_reg <= 7'h00;
      pin_sync_reg <= 7'h00;
    end
    else
    begin
      pin_meta_reg <= {tli_pin_i, ext_pin_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Edge history on synchronised levels only
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      tli_prev_reg <= 1'b0;
      ext_prev_reg <= 3'h0;
    end
    else
    begin
      tli_prev_reg <= pin_sync_reg[6];
      ext_prev_reg <= ext_level;
    end
  end

  assign tli_edge = pin_sync_reg[6] & ~tli_prev_reg;

  // External line conditioning: pin select in misc_config_three, sense in misc_config_one
  genvar e;
  generate
    for (e = 0; e < 3; e++)
    begin : g_ext
      logic [1:0] sel;
      logic [1:0] pins;
      logic [1:0] sense;
      assign sel   = misc3_reg[2*e +: 2];
      assign pins  = pin_sync_reg[2*e +: 2];
      assign sense = misc1_reg[2*e +: 2];
      // Request is high when any selected pin is low; nothing selected gives no request
      assign ext_level[e] = (|sel) & ~(&(pins | ~sel));
      // 00 level, 01 rising, 10 falling, 11 both edges
      assign ext_is_level[e] = (sense == 2'b00);
      assign ext_evt[e] = (sense[0] & ext_level[e] & ~ext_prev_reg[e]) |
                          (sense[1] & ~ext_level[e] & ext_prev_reg[e]);
    end
  endgenerate

  // Per slot request latches
  genvar s;
  generate
    for (s = 1; s < 14; s++)
    begin : g_slot
      localparam int EXT = (s == `NIC_EXT0_SLOT) ? 0 :
                           (s == `NIC_EXT1_SLOT) ? 1 :
                           (s == `NIC_EXT2_SLOT) ? 2 : 3;
      logic entry_clr;
      assign entry_clr = (state_reg == nic_pkg::ST_LOAD) & sel_mask_reg & (sel_idx_reg == 4'(s));
      if (EXT < 3)
      begin : g_ext_slot
        // Edge latch, cleared on handler entry; a new edge in that cycle wins
        assign lat_next[s] = ext_evt[EXT] | (lat_reg[s] & ~entry_clr);
        assign pend[s]     = ext_is_level[EXT] ? ext_level[EXT] : lat_reg[s];
      end
      else
      begin : g_per_slot
        // Latch follows flag and enable; the clear sequence drops it
        assign lat_next[s] = (periph_flag_i[s] & periph_en_i[s]) |
                             (lat_reg[s] & ~periph_clr_i[s]);
        assign pend[s]     = lat_reg[s] & periph_en_i[s] & periph_flag_i[s];
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      lat_reg <= 13'h0000;
    else
      lat_reg <= lat_next;
  end

  // Maskable arbitration: scanning downward lets equal ranks fall to lower slots
  always_comb
  begin
    best_valid = 1'b0;
    best_idx   = 4'h0;
    best_rank  = 2'h0;
    for (int i = 13; i >= 1; i--)
    begin
      if (pend[i] && (lvl_rank(prio_reg[i]) > lvl_rank(level_reg)) &&
          (!halted_reg || halt_cap[i]) &&
          (!best_valid || lvl_rank(prio_reg[i]) >= best_rank))
      begin
        best_valid = 1'b1;
        best_idx   = 4'(i);
        best_rank  = lvl_rank(prio_reg[i]);
      end
    end
  end

  // Non-maskable sources sit above every maskable one and ignore the level
  always_comb
  begin
    win_valid = 1'b1;
    win_vec   = `NIC_VEC_SLOT0;
    win_lvl   = `NIC_LVL3;
    if (trap_pend_reg)
      win_vec = `NIC_VEC_TRAP;
    else if (tli_pend_reg)
      win_vec = `NIC_VEC_SLOT0;
    else if (best_valid)
    begin
      win_vec = `NIC_VEC_SLOT0 - {11'h000, best_idx, 1'b0};
      win_lvl = prio_reg[best_idx];
    end
    else
      win_valid = 1'b0;
  end

  // Take only at an instruction boundary, or at once when the core sleeps
  assign take = (state_reg == nic_pkg::ST_RUN) & win_valid &
                (core_evt_i.instr_done | sleeping);

  // Service sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      nic_pkg::ST_RESET: state_next = nic_pkg::ST_RUN;
      nic_pkg::ST_RUN:   if (take) state_next = nic_pkg::ST_STACK;
      nic_pkg::ST_STACK: if (core_evt_i.stack_done) state_next = nic_pkg::ST_LOAD;
      nic_pkg::ST_LOAD:  state_next = nic_pkg::ST_RUN;
      default:           state_next = nic_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      state_reg <= nic_pkg::ST_RESET;
    else
      state_reg <= state_next;
  end

  // Capture the winner when taken
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sel_vec_reg   <= `NIC_VEC_RESET;
      sel_lvl_reg   <= `NIC_LVL3;
      sel_stack_reg <= 1'b0;
      sel_idx_reg   <= 4'h0;
      sel_mask_reg  <= 1'b0;
    end
    else if (take)
    begin
      sel_vec_reg   <= win_vec;
      sel_lvl_reg   <= win_lvl;
      sel_stack_reg <= 1'b1;
      sel_idx_reg   <= best_idx;
      sel_mask_reg  <= ~trap_pend_reg & ~tli_pend_reg;
    end
  end

  // Trap and pin latches; trap has priority so it is cleared first on entry
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      trap_pend_reg <= 1'b0;
      tli_pend_reg  <= 1'b0;
    end
    else
    begin
      trap_pend_reg <= core_evt_i.trap | (trap_pend_reg & ~take);
      // A pin edge during a trap handler stays pending and preempts at level 3
      tli_pend_reg  <= tli_edge | (tli_pend_reg & ~(take & ~trap_pend_reg));
    end
  end

  // Level bits: entry, then return, then software loads, then sleep entry
  always_comb
  begin
    level_next = level_reg;
    if (state_reg == nic_pkg::ST_RESET)
      level_next = `NIC_LVL3;
    else if (state_reg == nic_pkg::ST_LOAD)
      level_next = sel_lvl_reg;
    else if (core_evt_i.return_from_interrupt)
      level_next = core_evt_i.level;
    else if (core_evt_i.level_wr)
      level_next = core_evt_i.level;
    else if (core_evt_i.halt_enter | core_evt_i.wait_enter)
      level_next = `NIC_LVL0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      level_reg <= `NIC_LVL3;
    else
      level_reg <= level_next;
  end

  // Low power state: taking a request is the wake-up
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      halted_reg  <= 1'b0;
      waiting_reg <= 1'b0;
    end
    else if (take)
    begin
      halted_reg  <= 1'b0;
      waiting_reg <= 1'b0;
    end
    else
    begin
      if (core_evt_i.halt_enter)
        halted_reg <= 1'b1;
      if (core_evt_i.wait_enter)
        waiting_reg <= 1'b1;
    end
  end

  // Commands to the core; reset loads the vector with no stacking
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      svc_cmd_o <= '0;
    else
    begin
      svc_cmd_o.stack_req <= take;
      svc_cmd_o.pc_load   <= (state_reg == nic_pkg::ST_LOAD) ||
                             (state_reg == nic_pkg::ST_RESET);
      if (state_reg == nic_pkg::ST_RESET)
        svc_cmd_o.vector <= `NIC_VEC_RESET;
      else if (state_reg == nic_pkg::ST_LOAD)
        svc_cmd_o.vector <= sel_vec_reg;
    end
  end

  // Software registers; a level 0 pattern leaves that field alone
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      for (int k = 0; k < 14; k++)
        prio_reg[k] <= `NIC_PRIO_RST;
      misc1_reg <= `NIC_MISC_RST;
      misc3_reg <= `NIC_MISC_RST;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i <= `NIC_OFS_PRIO3)
      begin
        for (int k = 0; k < 4; k++)
        begin
          if ((4 * int'(reg_addr_i) + k < 14) && (reg_wdata_i[2*k +: 2] != `NIC_LVL0))
            prio_reg[4 * int'(reg_addr_i) + k] <= reg_wdata_i[2*k +: 2];
        end
      end
      if (reg_addr_i == `NIC_OFS_MISC1)
        misc1_reg <= reg_wdata_i;
      if (reg_addr_i == `NIC_OFS_MISC3)
        misc3_reg <= reg_wdata_i;
    end
  end

  assign pend_all = {pend, tli_pend_reg};

  // Read selection; the top of the last priority register reads as ones
  always_comb
  begin
    rd_mux = 8'h00;
    case (reg_addr_i)
      8'h00: rd_mux = {prio_reg[3], prio_reg[2], prio_reg[1], prio_reg[0]};
      8'h01: rd_mux = {prio_reg[7], prio_reg[6], prio_reg[5], prio_reg[4]};
      8'h02: rd_mux = {prio_reg[11], prio_reg[10], prio_reg[9], prio_reg[8]};
      `NIC_OFS_PRIO3:   rd_mux = {4'hf, prio_reg[13], prio_reg[12]};
      `NIC_OFS_MISC1:   rd_mux = misc1_reg;
      `NIC_OFS_MISC3:   rd_mux = misc3_reg;
      `NIC_OFS_STATUS:  rd_mux = {3'h0, (state_reg != nic_pkg::ST_RUN), waiting_reg,
                                  halted_reg, level_reg};
      `NIC_OFS_PEND_LO: rd_mux = pend_all[7:0];
      `NIC_OFS_PEND_HI: rd_mux = {1'b0, trap_pend_reg, pend_all[13:8]};
      default:          rd_mux = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
  end

  // Mirror flops for the core side
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      cc_level_o <= `NIC_LVL3;
      halted_o   <= 1'b0;
      waiting_o  <= 1'b0;
    end
    else
    begin
      cc_level_o <= level_next;
      halted_o   <= halted_reg & ~take;
      waiting_o  <= waiting_reg & ~take;
    end
  end

endmodule

// File: design/nic_cfg.svh
`ifndef NIC_CFG_SVH
`define NIC_CFG_SVH
// How it works
// - Current level lives in two bits: 10 main, 01, 00, 11 interrupts disabled.
// - Sixteen fixed vectors at the top of memory, ordered by hardware priority.
// - A request is taken only at an instruction boundary, or at once while the core halts or waits.
// - Entry asks the core to push PC, X, A and the condition codes.
// - Entry loads the level bits from the serviced vector's stored priority.
// - After stacking the vector address is handed to the core for fetch.
// - Return restores the stacked level bits so the interrupted level resumes.
// - Highest software priority wins, ties go to the highest hardware priority.
// - Hardware priorities are unique, so one winner always comes out.
// - Unserviced edge and peripheral requests stay latched until they become the highest; level-sensed lines are not latched.
// - Maskable requests need enable and priority above the current level.
// - Reset, trap and pin interrupt ignore the level and set level 3.
// - Each non-maskable source wakes the core from halt.
// - The pin interrupt fires on a rising edge of its pin.
// - Trap is handled like the pin interrupt; the pin may preempt a trap.
// - Reset ranks above everything and starts code at level 3.
// - Edge requests are latched and cleared on handler entry; sense is selectable.
// - Selected pins of one group are NANDed into one request.
// - A peripheral request stands only while flag and enable are both set.
// - The flag-clearing sequence drops the request latch, losing pending work.
// - Any request wakes from wait, only halt-capable ones wake from halt.
// - Leaving halt, the first served request is the best halt-capable one, not the normal choice.
// - Writing the level 0 pattern into a priority field keeps the old value.
// - Raising a running vector's priority while pending re-enters its handler.

// Register offsets
`define NIC_OFS_PRIO0      8'h00
`define NIC_OFS_PRIO3      8'h03
`define NIC_OFS_MISC1      8'h04
`define NIC_OFS_MISC3      8'h05
`define NIC_OFS_STATUS     8'h06
`define NIC_OFS_PEND_LO    8'h07
`define NIC_OFS_PEND_HI    8'h08
// Level encodings
`define NIC_LVL0           2'b10
`define NIC_LVL3           2'b11
// Reset values
`define NIC_PRIO_RST       2'b11
`define NIC_MISC_RST       8'h00
// Vector addresses
`define NIC_VEC_RESET      16'hfffe
`define NIC_VEC_TRAP       16'hfffc
`define NIC_VEC_SLOT0      16'hfffa
// Slots wired to the three external lines, and halt exit capability per slot
`define NIC_EXT0_SLOT      2
`define NIC_EXT1_SLOT      6
`define NIC_EXT2_SLOT      9
`define NIC_HALT_CAP       14'b00_0110_0110_0111
`endif

// File: design/nic_pkg.sv
package nic_pkg;
  typedef enum logic [1:0] {
    ST_RESET,
    ST_RUN,
    ST_STACK,
    ST_LOAD
  } ctl_state_t;

  // Events from the core, all one-cycle pulses except level
  typedef struct packed {
    logic       instr_done;
    logic       trap;
    logic       return_from_interrupt;
    logic       level_wr;
    logic       halt_enter;
    logic       wait_enter;
    logic       stack_done;
    logic [1:0] level;
  } core_evt_t;

  // Service commands to the core
  typedef struct packed {
    logic        stack_req;
    logic        pc_load;
    logic [15:0] vector;
  } svc_cmd_t;
endpackage

// File: sim/core_model.sv
`timescale 1ns/1ps
module core_model
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  // Bench events and push delay
  input  wire nic_pkg::core_evt_t bench_evt_i,
  input  wire logic [3:0]         stack_dly_i,
  // Controller side
  input  wire nic_pkg::svc_cmd_t  svc_cmd_i,
  output nic_pkg::core_evt_t      core_evt_o
);
  logic [1:0] step_reg;
  logic [3:0] dly_reg;
  logic       busy_reg;

  // Instructions end every third cycle; a push takes the chosen delay
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      step_reg <= 2'h0;
      busy_reg <= 1'b0;
      dly_reg  <= 4'h0;
    end
    else
    begin
      step_reg <= (step_reg == 2'h2) ? 2'h0 : step_reg + 2'h1;
      if (svc_cmd_i.stack_req)
      begin
        busy_reg <= 1'b1;
        dly_reg  <= stack_dly_i;
      end
      else if (busy_reg && dly_reg == 4'h0)
        busy_reg <= 1'b0;
      else if (busy_reg)
        dly_reg <= dly_reg - 4'h1;
    end
  end

  // No boundary while pushing, so the take stays at an instruction end
  always_comb
  begin
    core_evt_o            = bench_evt_i;
    core_evt_o.instr_done = (step_reg == 2'h0) && !busy_reg;
    core_evt_o.stack_done = busy_reg && (dly_reg == 4'h0);
  end
endmodule

// File: sim/nested_priority_interrupt_ctrl_bench.sv
`timescale 1ns/1ps
module nested_priority_interrupt_ctrl_bench;
  localparam logic [6:0] e_lwr  = 7'h08;
  localparam logic [6:0] e_return_from_interrupt = 7'h10;
  localparam logic [6:0] e_trap = 7'h20;
  localparam logic [6:0] e_halt = 7'h04;
  localparam logic [6:0] e_wait = 7'h02;
  logic               clk_i;
  logic               rst_b_i;
  logic [7:0]         reg_addr_i;
  logic [7:0]         reg_wdata_i;
  logic               reg_wr_i;
  logic               reg_rd_i;
  logic [7:0]         reg_rdata_o;
  nic_pkg::core_evt_t ev;
  nic_pkg::core_evt_t core_evt;
  nic_pkg::svc_cmd_t  svc_cmd_o;
  logic [1:0]         cc_level_o;
  logic               halted_o;
  logic               waiting_o;
  logic [13:1]        flag;
  logic [13:1]        en;
  logic [13:1]        clr;
  logic               top_level_pin_interrupt;
  logic [5:0]         pins;
  logic [3:0]         dly;
  int                 n_mismatch;
  int                 n_compared;
  int                 i;
  logic [7:0]         shadow [4] = '{8'hff, 8'hff, 8'hff, 8'hff};
  // Ordinary rows: slot, stored priority, expected vector
  logic [3:0]         row_slot [4] = '{4'h1, 4'h4, 4'hd, 4'h8};
  logic [1:0]         row_prio [4] = '{2'b01, 2'b00, 2'b01, 2'b00};
  logic [15:0]        row_vec [4] = '{16'hfff8, 16'hfff2, 16'hffe0, 16'hffea};

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  nested_priority_interrupt_ctrl dut (.clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .core_evt_i(core_evt), .svc_cmd_o, .cc_level_o,
    .halted_o, .waiting_o, .periph_flag_i(flag), .periph_en_i(en), .periph_clr_i(clr),
    .tli_pin_i(top_level_pin_interrupt), .ext_pin_i(pins));
  core_model core (.clk_i, .rst_b_i, .bench_evt_i(ev), .stack_dly_i(dly),
    .svc_cmd_i(svc_cmd_o), .core_evt_o(core_evt));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, reg_rdata_o});
  endtask
  task automatic pr(input logic [3:0] k, input logic [1:0] p);
    shadow[k[3:2]][2*k[1:0] +: 2] = p;
    wr({6'h00, k[3:2]}, shadow[k[3:2]]);
  endtask
  task automatic evt(input logic [6:0] f, input logic [1:0] v);
    @(posedge clk_i);
    ev <= nic_pkg::core_evt_t'({f, v});
    @(posedge clk_i);
    ev <= '0;
  endtask
  task automatic take(input logic [15:0] vec, input logic [1:0] lv);
    int k;
    k = 0;
    while (svc_cmd_o.pc_load !== 1'b1 && k < 60)
    begin
      tick(1);
      k++;
    end
    chk("timeout", 16'h0, {15'h0, k == 60});
    chk("vector", vec, svc_cmd_o.vector);
    tick(1);
    chk("level", {14'h0, lv}, {14'h0, cc_level_o});
  endtask
  task automatic quiet(input int n);
    int c;
    c = 0;
    repeat (n)
    begin
      tick(1);
      c += svc_cmd_o.stack_req;
    end
    chk("takes", 16'h0, c[15:0]);
  endtask
  task automatic src(input logic [3:0] k);
    @(posedge clk_i);
    flag[k] <= 1'b1;
    en[k]   <= 1'b1;
  endtask
  task automatic fin(input logic [3:0] k, input logic [1:0] lv);
    @(posedge clk_i);
    flag[k] <= 1'b0;
    en[k]   <= 1'b0;
    clr[k]  <= 1'b1;
    @(posedge clk_i);
    clr[k]  <= 1'b0;
    evt(e_return_from_interrupt, lv);
    tick(2);
  endtask
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang is cut short well after the expected few hundred cycles
  initial
  begin
    #100000;
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    n_mismatch  = 0;
    n_compared  = 0;
    rst_b_i     = 1'b0;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    ev          = '0;
    flag        = '0;
    en          = '0;
    clr         = '0;
    top_level_pin_interrupt         = 1'b0;
    pins        = 6'h3f;
    dly         = 4'h0;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    take(16'hfffe, 2'b11);
    rd(8'h00, 8'hff);
    rd(8'h20, 8'h00);
    wr(8'h03, 8'h0f);
    rd(8'h03, 8'hff);
    wr(8'h01, 8'hcf);
    wr(8'h01, 8'h64);
    rd(8'h01, 8'h44);
    wr(8'h01, 8'hff);
    evt(e_lwr, 2'b10);
    tick(3);
    chk("level", 16'h2, {14'h0, cc_level_o});
    // One source at a time, each at its own stored level
    for (i = 0; i < 4; i++)
    begin
      pr(row_slot[i], row_prio[i]);
      src(row_slot[i]);
      take(row_vec[i], row_prio[i]);
      fin(row_slot[i], 2'b10);
      chk("level", 16'h2, {14'h0, cc_level_o});
      pr(row_slot[i], 2'b11);
    end
    // Held off by the current level, then served once it drops
    pr(4'h3, 2'b01);
    evt(e_lwr, 2'b01);
    src(4'h3);
    quiet(20);
    evt(e_lwr, 2'b10);
    take(16'hfff4, 2'b01);
    fin(4'h3, 2'b10);
    // Three at once: higher level first, then lower slot among equals
    pr(4'h4, 2'b01);
    pr(4'h7, 2'b00);
    @(posedge clk_i);
    flag[7:3] <= 5'h13;
    en[7:3]   <= 5'h13;
    take(16'hffec, 2'b00);
    fin(4'h7, 2'b10);
    take(16'hfff4, 2'b01);
    fin(4'h3, 2'b10);
    take(16'hfff2, 2'b01);
    fin(4'h4, 2'b10);
    pr(4'h7, 2'b11);
    // Slow pushes; trap at level 3, then the pin preempts it
    dly <= 4'h5;
    evt(e_lwr, 2'b11);
    evt(e_trap, 2'b11);
    take(16'hfffc, 2'b11);
    @(posedge clk_i);
    top_level_pin_interrupt <= 1'b1;
    take(16'hfffa, 2'b11);
    top_level_pin_interrupt <= 1'b0;
    evt(e_return_from_interrupt, 2'b11);
    evt(e_return_from_interrupt, 2'b10);
    dly <= 4'h0;
    // Halt: the capable source goes first although it ranks lower
    pr(4'h5, 2'b01);
    evt(e_halt, 2'b10);
    tick(2);
    chk("halted", 16'h1, {15'h0, halted_o});
    src(4'h3);
    src(4'h5);
    take(16'hfff0, 2'b01);
    chk("halted", 16'h0, {15'h0, halted_o});
    fin(4'h5, 2'b10);
    take(16'hfff4, 2'b01);
    fin(4'h3, 2'b10);
    evt(e_wait, 2'b10);
    tick(2);
    chk("waiting", 16'h1, {15'h0, waiting_o});
    src(4'h3);
    take(16'hfff4, 2'b01);
    fin(4'h3, 2'b10);
    // Line 0, rising edge of the combined pins, two pins selected
    pr(4'h2, 2'b01);
    wr(8'h04, 8'h01);
    wr(8'h05, 8'h03);
    tick(4);
    pins[0] <= 1'b0;
    take(16'hfff6, 2'b01);
    evt(e_return_from_interrupt, 2'b10);
    quiet(20);
    // Line 1 at level sense: pending only while the pin is held low
    pr(4'h6, 2'b01);
    wr(8'h05, 8'h0f);
    @(posedge clk_i);
    pins[2] <= 1'b0;
    take(16'hffee, 2'b01);
    @(posedge clk_i);
    pins[2] <= 1'b1;
    tick(2);
    evt(e_return_from_interrupt, 2'b10);
    quiet(20);
    // Line 1 at falling sense: a rising edge is ignored, the falling one latches
    wr(8'h04, 8'h09);
    @(posedge clk_i);
    pins[2] <= 1'b0;
    quiet(10);
    @(posedge clk_i);
    pins[2] <= 1'b1;
    take(16'hffee, 2'b01);
    evt(e_return_from_interrupt, 2'b10);
    quiet(20);
    wrap_up();
  end
endmodule

// File: sim/nic_props.sv
`timescale 1ns/1ps
module nic_props
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  // Watched ports
  input  wire logic               reg_rd_i,
  input  wire logic [7:0]         reg_rdata_o,
  input  wire nic_pkg::core_evt_t core_evt_i,
  input  wire nic_pkg::svc_cmd_t  svc_cmd_o,
  input  wire logic [1:0]         cc_level_o,
  input  wire logic               halted_o,
  input  wire logic               waiting_o
);
  logic stk_reg;
  logic stk_next;

  // Open from the stacking request until the core says the push is done
  assign stk_next = svc_cmd_o.stack_req | (stk_reg & ~core_evt_i.stack_done);
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      stk_reg <= 1'b0;
    else
      stk_reg <= stk_next;
  end

  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // A level write is ignored while a load can override it, so skip those cycles
  property lvl_follow_p;
    logic [1:0] v;
    (core_evt_i.return_from_interrupt || core_evt_i.level_wr) && !stk_reg && !$past(core_evt_i.stack_done)
      ##0 (1'b1, v = core_evt_i.level) |-> ##[1:2] cc_level_o == v;
  endproperty

  load_after_stack_a: assert property (stk_reg && core_evt_i.stack_done |-> ##2 svc_cmd_o.pc_load)
    else $error("vector load missing after stacking");
  take_boundary_a: assert property (svc_cmd_o.stack_req |->
    $past(core_evt_i.instr_done) || $past(halted_o) || $past(waiting_o))
    else $error("stacking started mid instruction");
  stack_pulse_a: assert property (svc_cmd_o.stack_req |=> !svc_cmd_o.stack_req)
    else $error("stack request longer than one cycle");
  reset_vector_a: assert property ($rose(rst_b_i) |->
    ##[0:3] svc_cmd_o.pc_load && svc_cmd_o.vector == 16'hfffe)
    else $error("reset vector not loaded");
  nmi_level_a: assert property (svc_cmd_o.pc_load &&
    svc_cmd_o.vector inside {16'hfffe, 16'hfffc, 16'hfffa} |-> ##[0:1] cc_level_o == 2'b11)
    else $error("non-maskable entry without level 3");
  mask_level_a: assert property (svc_cmd_o.pc_load && svc_cmd_o.vector < 16'hfffa |->
    ##[0:1] cc_level_o != 2'b10)
    else $error("maskable entry left level 0");
  vector_hold_a: assert property (!svc_cmd_o.pc_load && $past(rst_b_i) |-> $stable(svc_cmd_o.vector))
    else $error("vector changed without load");
  rdata_idle_a: assert property (!$past(reg_rd_i) && $past(rst_b_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  level_follow_a: assert property (lvl_follow_p)
    else $error("level bits not restored");

  trap_cov: cover property (svc_cmd_o.pc_load && svc_cmd_o.vector == 16'hfffc);
  pin_cov: cover property (svc_cmd_o.pc_load && svc_cmd_o.vector == 16'hfffa);
  halt_cov: cover property ($rose(halted_o));
endmodule

bind nested_priority_interrupt_ctrl nic_props chk (.clk_i, .rst_b_i, .reg_rd_i, .reg_rdata_o,
  .core_evt_i, .svc_cmd_o, .cc_level_o, .halted_o, .waiting_o);
